//--- rtl/sbc_defines.svh
// timing constants and reset values of the system-basis-chip mode and watchdog logic
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH
`define MCLK_HZ             10000000
`define UV_RESET_MS         4
`define UV_RESET_CYC        ((`UV_RESET_MS * `MCLK_HZ) / 1000)
`define OSC_RESISTOR_PIN_DIV_DEFAULT  20
`define WD_LEAD_OSC         7750
`define WD_CLOSED_OSC       1000
`define WD_OPEN_OSC         1000
`define WD_RESET_OSC        200
`define RESET_OUT_N_RST     1'b0
`endif

//--- rtl/sbc_pkg.sv
// types shared by the system-basis-chip mode and watchdog logic
package sbc_pkg;
  typedef enum logic [1:0] {
    MODE_FAIL_SAFE = 2'b00,
    MODE_NORMAL    = 2'b01,
    MODE_SILENT    = 2'b10,
    MODE_SLEEP     = 2'b11
  } sbc_mode_t;

  typedef enum logic [2:0] {
    WD_OFF    = 3'b000,
    WD_LEAD   = 3'b001,
    WD_CLOSED = 3'b010,
    WD_OPEN   = 3'b011,
    WD_RESET  = 3'b100
  } wd_state_t;
endpackage

//--- rtl/osc_tick_gen.sv
// divider that stands in for the resistor-set watchdog oscillator
`timescale 1ns/1ps
module osc_tick_gen #(
  parameter int unsigned DIV_W = 16
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] div,
  output logic                  tick
);
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic             wrap;

  // one tick per divider wrap; a zero or one divider ticks every cycle
  assign wrap    = run && (cnt_r + DIV_W'(1) >= div);
  assign cnt_nxt = (!run || wrap) ? '0 : cnt_r + DIV_W'(1);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= wrap;
    end
  end
endmodule

//--- rtl/sbc_mode_watchdog.sv
// mode control, window watchdog and transceiver gating of the basis chip
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_mode_watchdog
  import sbc_pkg::*;
#(
  parameter int unsigned DIV_W       = 16,
  parameter int unsigned CNT_W       = 16,
  parameter int unsigned LEAD_OSC    = `WD_LEAD_OSC,
  parameter int unsigned CLOSED_OSC  = `WD_CLOSED_OSC,
  parameter int unsigned OPEN_OSC    = `WD_OPEN_OSC,
  parameter int unsigned WDRST_OSC   = `WD_RESET_OSC,
  parameter int unsigned UV_CYC      = `UV_RESET_CYC
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             enable,
  input  wire logic             sleep_req,
  input  wire logic             silent_req,
  input  wire logic             wake_req,
  input  wire logic             debug_mode,
  input  wire logic             undervoltage,
  input  wire logic             watchdog_trigger_n,
  input  wire logic             watchdog_trigger_n_oe,
  input  wire logic [DIV_W-1:0] osc_resistor_pin,
  input  wire logic             txd,
  input  wire logic             lin_bus_in,
  output logic                  lin_bus_out,
  output logic                  lin_bus_oe,
  output logic                  rxd,
  output logic                  regulator_on,
  output logic                  inhibit_on,
  output logic                  reset_out_n,
  output logic                  reset_out_n_oe,
  output sbc_mode_t             mode,
  output wd_state_t             wd_state
);
  sbc_mode_t        mode_r;
  sbc_mode_t        mode_nxt;
  wd_state_t        wd_r;
  wd_state_t        wd_nxt;
  logic [CNT_W-1:0] wd_cnt_r;
  logic [CNT_W-1:0] wd_cnt_nxt;
  logic [31:0]      uv_cnt_r;
  logic [31:0]      uv_cnt_nxt;
  logic             trig_prev_r;
  logic             trig_lvl;
  logic             trig_fall;
  logic             osc_tick;
  logic             wd_run;
  logic             cnt_done;
  logic             uv_active;
  logic             wd_fail;
  logic             rst_low;
  logic             rxd_r;
  logic             bus_drive_r;
  logic [CNT_W-1:0] cnt_dec;
  logic             in_normal;
  logic             in_fail_safe;
  logic             next_normal;
  logic             in_pulse;
  logic             good_trig;
  logic             early_trig;
  logic             window_miss;

  // phase reload values; a phase of n periods counts n-1 down to zero
  localparam logic [CNT_W-1:0] LEAD_LOAD   = CNT_W'(LEAD_OSC - 1);
  localparam logic [CNT_W-1:0] CLOSED_LOAD = CNT_W'(CLOSED_OSC - 1);
  localparam logic [CNT_W-1:0] OPEN_LOAD   = CNT_W'(OPEN_OSC - 1);
  localparam logic [CNT_W-1:0] WDRST_LOAD  = CNT_W'(WDRST_OSC - 1);
  localparam logic [31:0]      UV_LOAD     = 32'(UV_CYC);

  assign trig_lvl  = watchdog_trigger_n_oe ? watchdog_trigger_n : 1'b1;
  assign trig_fall = trig_prev_r && !trig_lvl;

  // mode decode shared by watchdog gate, transceiver and supply pins
  assign in_normal    = (mode_r == MODE_NORMAL);
  assign in_fail_safe = (mode_r == MODE_FAIL_SAFE);
  // pins are registered from the next mode so they change with mode itself
  assign next_normal  = (mode_nxt == MODE_NORMAL);

  // watchdog only in fail-safe or normal, not debug
  // debug strap stops only the watchdog; the other reset sources stay
  assign wd_run = !debug_mode && (in_normal || in_fail_safe);

  // oscillator period from resistor setting
  // divider stops with the watchdog, so each start sees a full period
  osc_tick_gen #(
    .DIV_W (DIV_W)
  ) u_osc (
    .mclk   (mclk),
    .resetn (resetn),
    .run    (wd_run),
    .div    (osc_resistor_pin),
    .tick   (osc_tick)
  );

  // remaining periods in the current phase reach zero
  assign cnt_done = osc_tick && (wd_cnt_r == '0);
  // count down once per period; loads below replace it on a phase change
  assign cnt_dec  = (osc_tick && wd_cnt_r != '0) ? wd_cnt_r - CNT_W'(1)
                                                 : wd_cnt_r;

  // phase decode; a trigger is judged by the phase it lands in
  assign in_pulse    = (wd_r == WD_RESET);
  // edges in lead time or open window are accepted
  assign good_trig   = trig_fall && (wd_r == WD_LEAD || wd_r == WD_OPEN);
  // an edge in the closed window is too early
  assign early_trig  = trig_fall && (wd_r == WD_CLOSED);
  // phase ran out with no edge; an edge on the last tick still wins
  assign window_miss = cnt_done && !trig_fall;

  // watchdog phase sequence
  // phase lengths count oscillator ticks; a phase entered on a trigger edge starts mid-period
  always_comb begin
    wd_nxt     = wd_r;
    wd_cnt_nxt = cnt_dec;

    if (!wd_run) begin
      // stopped watchdog forgets its phase and restarts with lead time
      wd_nxt     = WD_OFF;
      wd_cnt_nxt = '0;
    end else begin
      unique case (wd_r)
        WD_OFF: begin
          // start of watchdog operation loads the lead time
          wd_nxt     = WD_LEAD;
          wd_cnt_nxt = LEAD_LOAD;
        end

        WD_LEAD: begin
          // trigger in lead time counts as first open window
          if (good_trig) begin
            wd_nxt     = WD_CLOSED;
            wd_cnt_nxt = CLOSED_LOAD;
          end else if (window_miss) begin
            wd_nxt     = WD_RESET;
            wd_cnt_nxt = WDRST_LOAD;
          end
        end

        WD_CLOSED: begin
          if (early_trig) begin
            wd_nxt     = WD_RESET;
            wd_cnt_nxt = WDRST_LOAD;
          // closed window over, open window begins
          end else if (cnt_done) begin
            wd_nxt     = WD_OPEN;
            wd_cnt_nxt = OPEN_LOAD;
          end
        end

        WD_OPEN: begin
          if (good_trig) begin
            wd_nxt     = WD_CLOSED;
            wd_cnt_nxt = CLOSED_LOAD;
          end else if (window_miss) begin
            wd_nxt     = WD_RESET;
            wd_cnt_nxt = WDRST_LOAD;
          end
        end

        WD_RESET: begin
          // pulse over, start again with lead time while the host reboots
          if (cnt_done) begin
            wd_nxt     = WD_LEAD;
            wd_cnt_nxt = LEAD_LOAD;
          end
        end

        // codes 5 to 7 never occur; fall back to a clean restart
        default: begin
          wd_nxt     = WD_OFF;
          wd_cnt_nxt = '0;
        end
      endcase
    end
  end

  // undervoltage holds reset for the full 4 ms after it clears
  // 32-bit count so the full hold fits at any sensible clock rate
  assign uv_cnt_nxt = undervoltage ? UV_LOAD :
                      (uv_cnt_r != '0) ? uv_cnt_r - 32'h1 : '0;
  // undervoltage itself forces reset for as long as it lasts
  assign uv_active  = undervoltage || (uv_cnt_r != '0);
  assign wd_fail    = in_pulse;
  // both sources share one reset output
  assign rst_low    = uv_active || wd_fail;

  // mode transitions; a reset in normal mode or an undervoltage in silent or sleep falls back to fail-safe
  // a low enable alone keeps normal mode; a request picks the target
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      MODE_FAIL_SAFE: begin
        if (enable && !rst_low)
          mode_nxt = MODE_NORMAL;
      end

      MODE_NORMAL: begin
        // reset from either source wins; sleep wins over silent
        if (rst_low)
          mode_nxt = MODE_FAIL_SAFE;
        else if (!enable && sleep_req)
          mode_nxt = MODE_SLEEP;
        else if (!enable && silent_req)
          mode_nxt = MODE_SILENT;
      end

      MODE_SILENT,
      MODE_SLEEP: begin
        // local or remote wake returns to fail-safe
        // undervoltage wakes too, so the host sees a clean restart
        if (wake_req || uv_active)
          mode_nxt = MODE_FAIL_SAFE;
      end
    endcase
  end

  // state registers; trigger history starts high
  // history matches an idle pin, so reset release makes no false edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mode_r      <= MODE_FAIL_SAFE;
      wd_r        <= WD_OFF;
      wd_cnt_r    <= '0;
      uv_cnt_r    <= '0;
      trig_prev_r <= 1'b1;
    end else begin
      mode_r      <= mode_nxt;
      wd_r        <= wd_nxt;
      wd_cnt_r    <= wd_cnt_nxt;
      uv_cnt_r    <= uv_cnt_nxt;
      trig_prev_r <= trig_lvl;
    end
  end

  // registered pin outputs
  // rxd rests high and the bus recessive whenever the transceiver is off
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      // reset output held low until the first clock after power-up
      reset_out_n <= `RESET_OUT_N_RST;
      rxd_r       <= 1'b1;
      bus_drive_r <= 1'b0;
    end else begin
      // reset output low only on failure
      reset_out_n <= !rst_low;
      rxd_r       <= next_normal ? lin_bus_in : 1'b1;
      // transmit low pulls the bus dominant
      bus_drive_r <= next_normal && !txd;
    end
  end

  // open drain: drive only the low level
  assign reset_out_n_oe = !reset_out_n;
  assign lin_bus_out    = 1'b0;

  // dominant bus while transmit input low
  assign lin_bus_oe     = bus_drive_r;
  assign rxd            = rxd_r;

  // regulator on outside sleep, so silent mode keeps the host alive
  assign regulator_on   = (mode_r != MODE_SLEEP);
  // external parts powered only while the chip is awake
  assign inhibit_on     = in_normal || in_fail_safe;
  assign mode           = mode_r;
  assign wd_state       = wd_r;
endmodule

//--- verification/sbc_mode_watchdog_properties.sv
// port-level checks of the mode, watchdog and transceiver logic
`timescale 1ns/1ps
module sbc_mode_watchdog_properties
  import sbc_pkg::*;
(
  input wire logic      mclk,
  input wire logic      resetn,
  input wire logic      enable,
  input wire logic      debug_mode,
  input wire logic      undervoltage,
  input wire logic      watchdog_trigger_n,
  input wire logic      watchdog_trigger_n_oe,
  input wire logic      txd,
  input wire logic      lin_bus_in,
  input wire logic      lin_bus_oe,
  input wire logic      rxd,
  input wire logic      reset_out_n,
  input wire sbc_mode_t mode,
  input wire wd_state_t wd_state
);
  // pin level seen inside; a released pin reads high
  wire trig = !watchdog_trigger_n_oe || watchdog_trigger_n;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_gate; mode != MODE_NORMAL |-> rxd && !lin_bus_oe; endproperty
  a_gate: assert property (p_gate) else $error("line open");
  property p_pass; mode == MODE_NORMAL |->
    lin_bus_oe == !$past(txd) && rxd == $past(lin_bus_in); endproperty
  a_pass: assert property (p_pass) else $error("line copy");
  property p_wdrst; wd_state == WD_RESET |=> !reset_out_n; endproperty
  a_wdrst: assert property (p_wdrst) else $error("no wd reset");
  property p_early; wd_state == WD_CLOSED && $past(trig) && !trig &&
    !debug_mode |=> wd_state == WD_RESET; endproperty
  a_early: assert property (p_early) else $error("early edge");
  property p_good; wd_state == WD_OPEN && $past(trig) && !trig &&
    !debug_mode |=> wd_state == WD_CLOSED; endproperty
  a_good: assert property (p_good) else $error("good edge");
  property p_float; wd_state == WD_CLOSED && !watchdog_trigger_n_oe &&
    !undervoltage |=> wd_state != WD_RESET; endproperty
  a_float: assert property (p_float) else $error("open pin edge");
  property p_quiet; mode[1] && $past(mode[1]) |-> wd_state == WD_OFF;
  endproperty
  a_quiet: assert property (p_quiet) else $error("wd in low power");
  property p_en; mode == MODE_FAIL_SAFE && enable && reset_out_n &&
    !undervoltage && wd_state != WD_RESET |=> mode == MODE_NORMAL;
  endproperty
  a_en: assert property (p_en) else $error("no normal mode");
  property p_uv; undervoltage |=> !reset_out_n; endproperty
  a_uv: assert property (p_uv) else $error("no uv reset");
endmodule

bind sbc_mode_watchdog sbc_mode_watchdog_properties u_props (.mclk, .resetn,
  .enable, .debug_mode, .undervoltage, .watchdog_trigger_n, .txd,
  .watchdog_trigger_n_oe, .lin_bus_in, .lin_bus_oe, .rxd, .reset_out_n,
  .mode, .wd_state);

//--- verification/host_mcu_model.sv
// host stand-in driving the enable and trigger pins
`timescale 1ns/1ps
module host_mcu_model (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic en_req,
  input  wire logic fire,
  input  wire logic float_pin,
  output logic      enable,
  output logic      watchdog_trigger_n,
  output logic      watchdog_trigger_n_oe
);
  logic low_r;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      {enable, low_r} <= 2'b00;
    end else begin
      {enable, low_r} <= {en_req, fire};
    end
  end
  // released line shows low; device pull-up must win
  assign watchdog_trigger_n_oe = !float_pin;
  assign watchdog_trigger_n    = !float_pin && !low_r;
endmodule

//--- verification/lin_sbc_window_watchdog_ctrl_tb_top.sv
// self-checking bench for the mode and window watchdog block
`timescale 1ns/1ps
module lin_sbc_window_watchdog_ctrl_tb_top;
  import sbc_pkg::*;
  localparam int D = 3;
  localparam int LD = 8;
  logic        mclk = 0, resetn = 1, en_req = 1, fire = 0, float_pin = 0;
  logic        sleep_req = 0, silent_req = 0, wake_req = 0, debug_mode = 0;
  logic        undervoltage = 0, txd = 1, lin_bus_in = 1, enable, rxd;
  logic        watchdog_trigger_n, watchdog_trigger_n_oe, lin_bus_oe;
  logic        regulator_on, reset_out_n, inhibit_on, reset_out_n_oe;
  sbc_mode_t   mode;
  wd_state_t   wd_state;
  logic [31:0] seed = 32'h6ee9;
  int          num_errors = 0, cmp_count = 0, n;
  always #50 mclk = !mclk;
  sbc_mode_watchdog #(.LEAD_OSC(LD), .CLOSED_OSC(4), .OPEN_OSC(4),
    .WDRST_OSC(2), .UV_CYC(20)) u_dut (.mclk, .resetn, .enable, .sleep_req,
    .silent_req, .wake_req, .debug_mode, .undervoltage, .watchdog_trigger_n,
    .watchdog_trigger_n_oe, .osc_resistor_pin(16'(D)), .txd, .lin_bus_in,
    .lin_bus_out(), .lin_bus_oe, .rxd, .regulator_on, .inhibit_on,
    .reset_out_n, .reset_out_n_oe, .mode, .wd_state);
  host_mcu_model u_host (.mclk, .resetn, .en_req, .fire, .float_pin,
    .enable, .watchdog_trigger_n, .watchdog_trigger_n_oe);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // random line traffic; checked by the bound checker
  always @(posedge mclk) begin
    #1 seed = xs(seed);
    {txd, lin_bus_in} = seed[1:0];
  end
  task automatic chk(input logic [7:0] seen, exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic pulse;
    fire = 1;
    tk(1);
    fire = 0;
  endtask
  // bounded wait; n keeps the cycles spent
  task automatic wait_wd(input wd_state_t s);
    for (n = 0; n < 400 && wd_state !== s; n++) tk(1);
    if (n == 400) begin
      chk(0, 1, "wait");
      results();
    end
  endtask
  task automatic results;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    resetn = 0;
    tk(4);
    chk({mode, regulator_on}, 3'b001, "boot");
    tk(4);
    resetn = 1;
    wait_wd(WD_RESET);
    chk(n >= LD * D - D && n <= LD * D + D + 2, 1, "lead");
    tk(1);
    chk({reset_out_n, reset_out_n_oe, mode}, 4'b0100, "wd rst");
    wait_wd(WD_LEAD);
    tk(2);
    pulse();
    wait_wd(WD_CLOSED);
    repeat (4) begin
      wait_wd(WD_OPEN);
      chk(n >= 4 * D - D - 3 && n <= 4 * D + D, 1, "closed");
      tk(1 + seed[3:2]);
      pulse();
      wait_wd(WD_CLOSED);
      chk(n <= 3, 1, "accept");
      chk(reset_out_n, 1, "kept");
    end
    pulse();
    wait_wd(WD_RESET);
    chk(n <= 3, 1, "early");
    wait_wd(WD_LEAD);
    tk(2);
    pulse();
    wait_wd(WD_CLOSED);
    float_pin = 1;
    wait_wd(WD_OPEN);
    wait_wd(WD_RESET);
    chk(n >= 4 * D - D - 1 && n <= 4 * D + D, 1, "open");
    float_pin = 0;
    debug_mode = 1;
    tk(10);
    undervoltage = 1;
    tk(2);
    chk({reset_out_n, mode}, 3'b000, "uv");
    undervoltage = 0;
    tk(15);
    chk(reset_out_n, 0, "uv hold");
    tk(10);
    chk(reset_out_n, 1, "uv end");
    debug_mode = 0;
    tk(2);
    chk(mode, MODE_NORMAL, "on");
    chk({regulator_on, inhibit_on}, 2'b11, "supply on");
    for (int k = 0; k < 2; k++) begin
      en_req = 0;
      {sleep_req, silent_req} = (k == 0) ? 2'b10 : 2'b01;
      tk(3);
      chk(mode, k ? MODE_SILENT : MODE_SLEEP, "low pwr");
      chk({regulator_on, inhibit_on}, k ? 2'b10 : 2'b00, "supply");
      tk(30);
      chk(wd_state, WD_OFF, "wd off");
      chk({reset_out_n, rxd, lin_bus_oe}, 3'b110, "quiet");
      {sleep_req, silent_req, wake_req} = 3'b001;
      tk(2);
      wake_req = 0;
      en_req = 1;
      tk(3);
      chk(mode, MODE_NORMAL, "again");
    end
    results();
  end
endmodule
